/* design/uirc_ctrl.sv */
// UART interrupt, reset, sleep, time-out and break control
//
// Operation
// - All resets clear enable registers
// - Ident reads 0x01 after reset
// - Line control 0x1D, tx level 0x40
// - Line status 0x60; modem low cleared
// - Reset clears FIFO pointers
// - Flow character kept over every reset
// - Reset: tx, rts high; irq released
// - Enabled pending source asserts irq
// - Codes for line, timeout, data, tx hold
// - Codes for modem, gpio, flow-off
// - Handshake pin rise: lowest priority
// - FIFO error bit while errors remain
// - Head entry error flags, zero when empty
// - Flow-off cleared by flow-on; special by read
// - Sleep needs enhanced and sleep enable
// - Sleep only when idle and quiet
// - Sleep stops clock; wakes on activity
// - Time-out after four idle character times
// - Time-out restarts on stop bit, read
// - Break when rx low over one frame
// - Break setting forces tx low
// - Special char sets flow-off, stored
`timescale 1ns/1ps
module uirc_ctrl
    import uirc_pkg::*;
#(
    parameter int CHAR_W = 16
) (
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire logic               soft_reset,
    // Register writes and ident read from the host port
    input  wire logic               irq_enable_wr,
    input  wire logic [7:0]         irq_enable_wdata,
    input  wire logic               line_ctrl_wr,
    input  wire logic [7:0]         line_ctrl_wdata,
    input  wire logic               enh_feature_wr,
    input  wire logic [7:0]         enh_feature_wdata,
    input  wire logic               flow_char_wr,
    input  wire logic [7:0]         flow_char_wdata,
    input  wire logic               irq_ident_rd,
    // Receive and transmit datapath events, gpio change and character time
    input  wire logic               rx_char_valid,
    input  wire logic [7:0]         rx_char,
    input  wire logic               rx_parity_err,
    input  wire logic               rx_framing_err,
    input  wire logic               rx_stop_centre,
    input  wire logic               rx_fifo_rd,
    input  wire logic               rx_above_trigger,
    input  wire logic               flow_on_match,
    input  wire logic               flow_off_match,
    input  wire logic               tx_fifo_wr,
    input  wire logic               tx_hold_req,
    input  wire logic               tx_empty,
    input  wire logic               tx_serial_core,
    input  wire logic               rts_core,
    input  wire logic               gpio_change,
    input  wire logic [CHAR_W-1:0]  char_time,
    // Pins from outside
    input  wire logic               rx_pin,
    input  wire logic [3:0]         modem_pins,
    input  wire logic               cts_pin,
    // Outputs
    output logic [7:0]              irq_enable_reg,
    output logic [7:0]              line_ctrl_reg,
    output logic [7:0]              enhanced_feature_reg,
    output logic [7:0]              irq_ident_reg,
    output logic [7:0]              line_status_reg,
    output logic [7:0]              modem_status_reg,
    output logic [7:0]              tx_level_reg,
    output logic [6:0]              rx_level,
    output logic                    tx_serial,
    output logic                    rts_pin,
    output logic                    irq_n_out,
    output logic                    irq_n_oe,
    output logic                    uart_clk_en,
    output logic                    asleep
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [5:0] pins_s;
    logic       rx_s;
    logic [3:0] modem_s;
    logic       cts_s;

    uirc_sync #(.W(6)) u_sync (
        .sys_clk   (sys_clk),
        .async_in  ({cts_pin, modem_pins, rx_pin}),
        .sync_out  (pins_s)
    );

    assign rx_s    = pins_s[0];
    assign modem_s = pins_s[4:1];
    assign cts_s   = pins_s[5];

    // ------------------------------------------------------------
    // Receive FIFO error tracking
    // ------------------------------------------------------------
    logic [ERR_W-1:0] head_err;
    logic             any_err;
    logic             brk_det;

    uirc_err_fifo u_err_fifo (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n && !soft_reset),
        .push     (rx_char_valid),
        .push_err ({brk_det, rx_framing_err, rx_parity_err}),
        .pop      (rx_fifo_rd),
        .head_err (head_err),
        .any_err  (any_err),
        .level    (rx_level)
    );

    // ------------------------------------------------------------
    // Control registers and events
    // ------------------------------------------------------------
    logic       any_reset;
    logic [7:0] flow_off_char_2;
    logic [3:0] modem_prev;
    logic       cts_prev;
    logic       rts_prev;
    logic       modem_flag;
    logic       hshake_flag;
    logic       flow_off_flag;
    logic       special_flag;
    logic       timeout_flag;
    logic [CHAR_W+2:0] idle_count;
    logic [CHAR_W+1:0] low_count;
    logic       rx_prev;
    logic [7:0] next_irq_enable;
    logic [7:0] next_line_ctrl;
    logic [7:0] next_enh_feature;
    logic       next_modem_flag;
    logic       next_hshake_flag;
    logic       next_flow_off_flag;
    logic       next_special_flag;
    logic       next_timeout_flag;
    logic [CHAR_W+2:0] next_idle_count;
    logic [CHAR_W+1:0] next_low_count;
    logic       next_brk_det;
    logic [CHAR_W+2:0] timeout_limit;
    logic [CHAR_W+1:0] break_limit;
    logic       special_hit;
    logic       modem_change;

    assign any_reset     = !reset_n || soft_reset;
    // Break span is one character time
    assign timeout_limit = (CHAR_W+3)'(char_time) * (CHAR_W+3)'(RX_TIMEOUT_CHARS);
    assign break_limit   = (CHAR_W+2)'(char_time);
    assign special_hit   = rx_char_valid && enhanced_feature_reg[EFR_SPECIAL_BIT]
                           && (rx_char == flow_off_char_2);
    assign modem_change  = (modem_s != modem_prev);

    // Next register values; set wins over clear on every flag
    always_comb
    begin
        next_irq_enable  = irq_enable_wr ? irq_enable_wdata : irq_enable_reg;
        next_line_ctrl   = line_ctrl_wr ? line_ctrl_wdata : line_ctrl_reg;
        next_enh_feature = enh_feature_wr ? enh_feature_wdata : enhanced_feature_reg;
        next_modem_flag  = modem_change || (modem_flag && !irq_ident_rd);
        next_hshake_flag = (cts_s && !cts_prev) || (rts_core && !rts_prev)
                           || (hshake_flag && !irq_ident_rd);
        next_flow_off_flag = flow_off_match || (flow_off_flag && !flow_on_match);
        next_special_flag  = special_hit || (special_flag && !irq_ident_rd);
        // Idle counter restarts on stop centre or FIFO read
        if (rx_stop_centre || rx_fifo_rd || rx_level == '0)
            next_idle_count = '0;
        else if (idle_count != timeout_limit)
            next_idle_count = idle_count + 1'b1;
        else
            next_idle_count = idle_count;
        next_timeout_flag = (rx_level != '0) && !rx_above_trigger
                            && (idle_count == timeout_limit);
        // Break: rx low longer than a full frame
        if (rx_s)
            next_low_count = '0;
        else if (low_count != break_limit)
            next_low_count = low_count + 1'b1;
        else
            next_low_count = low_count;
        next_brk_det = !rx_s && (low_count == break_limit);
        if (any_reset)
        begin
            next_irq_enable    = '0;
            next_line_ctrl     = LINE_CTRL_RESET;
            next_enh_feature   = '0;
            next_modem_flag    = 1'b0;
            next_hshake_flag   = 1'b0;
            next_flow_off_flag = 1'b0;
            next_special_flag  = 1'b0;
            next_idle_count    = '0;
            next_timeout_flag  = 1'b0;
            next_low_count     = '0;
            next_brk_det       = 1'b0;
        end
    end

    // Register update
    always_ff @(posedge sys_clk)
    begin
        irq_enable_reg       <= next_irq_enable;
        line_ctrl_reg        <= next_line_ctrl;
        enhanced_feature_reg <= next_enh_feature;
        modem_flag           <= next_modem_flag;
        hshake_flag          <= next_hshake_flag;
        flow_off_flag        <= next_flow_off_flag;
        special_flag         <= next_special_flag;
        idle_count           <= next_idle_count;
        timeout_flag         <= next_timeout_flag;
        low_count            <= next_low_count;
        brk_det              <= next_brk_det;
        modem_prev           <= modem_s;
        cts_prev             <= cts_s;
        rts_prev             <= rts_core;
        rx_prev              <= rx_s;
    end

    // Flow character survives every reset
    always_ff @(posedge sys_clk)
    begin
        if (flow_char_wr)
            flow_off_char_2 <= flow_char_wdata;
    end

    // ------------------------------------------------------------
    // Interrupt prioritisation
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] pend;
    logic [5:0]         ident;
    logic               pend_any;

    // Sources in priority order, each but gpio gated by its enable
    always_comb
    begin
        pend[0] = any_err && irq_enable_reg[IER_LINE_BIT];
        pend[1] = timeout_flag && irq_enable_reg[IER_RX_DATA_BIT];
        pend[2] = rx_above_trigger && irq_enable_reg[IER_RX_DATA_BIT];
        pend[3] = tx_hold_req && irq_enable_reg[IER_TX_HOLD_BIT];
        pend[4] = modem_flag && irq_enable_reg[IER_MODEM_BIT];
        pend[5] = gpio_change;
        pend[6] = (flow_off_flag || special_flag) && irq_enable_reg[IER_FLOW_OFF_BIT];
        pend[7] = hshake_flag && irq_enable_reg[IER_HSHAKE_BIT];
        pend[8] = 1'b0;
        pend_any = |pend;
        // Smallest priority number wins
        if (pend[0])      ident = ID_LINE_STATUS;
        else if (pend[1]) ident = ID_RX_TIMEOUT;
        else if (pend[2]) ident = ID_RX_DATA;
        else if (pend[3]) ident = ID_TX_HOLD;
        else if (pend[4]) ident = ID_MODEM;
        else if (pend[5]) ident = ID_GPIO;
        else if (pend[6]) ident = ID_FLOW_OFF;
        else if (pend[7]) ident = ID_HANDSHAKE;
        else              ident = ID_NONE;
    end

    // ------------------------------------------------------------
    // Sleep control
    // ------------------------------------------------------------
    typedef enum logic {UIRC_AWAKE, UIRC_SLEEP} uirc_sleep_t;
    uirc_sleep_t sleep_state;
    uirc_sleep_t next_sleep_state;
    logic        may_sleep;
    logic        wake;

    // Only tx hold may be pending; rx idle and fifos empty
    always_comb
    begin
        may_sleep = enhanced_feature_reg[EFR_ENH_BIT] && irq_enable_reg[IER_SLEEP_BIT]
                    && rx_s && tx_empty && (rx_level == '0)
                    && ((pend & ~(NUM_SRC'(1) << 3)) == '0);
        wake      = (rx_s != rx_prev) || modem_change || tx_fifo_wr;
        case (sleep_state)
            UIRC_AWAKE: next_sleep_state = (may_sleep && !wake) ? UIRC_SLEEP : UIRC_AWAKE;
            UIRC_SLEEP: next_sleep_state = (wake || !may_sleep) ? UIRC_AWAKE : UIRC_SLEEP;
            default:    next_sleep_state = UIRC_AWAKE;
        endcase
        if (any_reset)
            next_sleep_state = UIRC_AWAKE;
    end

    always_ff @(posedge sys_clk)
    begin
        sleep_state <= next_sleep_state;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic [7:0] next_ident_reg;
    logic [7:0] next_lsr;
    logic [7:0] next_msr;
    logic       next_tx;
    logic       next_rts;
    logic       next_irq_oe;

    // Registered status and pins
    always_comb
    begin
        next_ident_reg = {2'b00, ident};
        next_lsr       = {any_err, tx_empty, tx_hold_req, head_err, 1'b0, rx_level != '0};
        next_msr       = {~modem_s, modem_flag, 3'b000};
        next_tx        = line_ctrl_reg[LCR_BREAK_BIT] ? 1'b0 : tx_serial_core;
        next_rts       = rts_core;
        next_irq_oe    = pend_any;
        if (any_reset)
        begin
            next_ident_reg = IDENT_RESET;
            next_lsr       = LINE_STAT_RESET;
            next_msr       = {~modem_s, 4'h0};
            next_tx        = 1'b1;
            next_rts       = 1'b1;
            next_irq_oe    = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        irq_ident_reg    <= next_ident_reg;
        line_status_reg  <= next_lsr;
        modem_status_reg <= next_msr;
        tx_serial        <= next_tx;
        rts_pin          <= next_rts;
        irq_n_oe         <= next_irq_oe;
    end

    // Open-drain interrupt drives low only
    assign irq_n_out    = 1'b0;
    assign tx_level_reg = TX_LEVEL_RESET;
    assign uart_clk_en  = (sleep_state == UIRC_AWAKE);
    assign asleep       = (sleep_state == UIRC_SLEEP);
endmodule

/* design/uirc_err_fifo.sv */
// Receive FIFO error tracker: per entry error flags and pointers
`timescale 1ns/1ps
module uirc_err_fifo
    import uirc_pkg::*;
#(
    parameter int DEPTH = uirc_pkg::FIFO_DEPTH,
    parameter int AW    = uirc_pkg::FIFO_AW
) (
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    input  wire logic               push,
    input  wire logic [uirc_pkg::ERR_W-1:0] push_err,
    input  wire logic               pop,
    output logic      [uirc_pkg::ERR_W-1:0] head_err,
    output logic                    any_err,
    output logic      [AW:0]        level
);
    logic [ERR_W-1:0] err_mem [DEPTH];
    logic [AW-1:0]    rd_ptr;
    logic [AW-1:0]    wr_ptr;
    logic [AW:0]      err_count;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW:0]      next_level;
    logic [AW:0]      next_err_count;
    logic             do_push;
    logic             do_pop;
    logic             pop_err;

    // Accept only when room or data exists
    always_comb
    begin
        do_push        = push && (level != (AW+1)'(DEPTH));
        do_pop         = pop && (level != '0);
        pop_err        = do_pop && (err_mem[rd_ptr] != '0);
        next_rd_ptr    = do_pop ? rd_ptr + 1'b1 : rd_ptr;
        next_wr_ptr    = do_push ? wr_ptr + 1'b1 : wr_ptr;
        next_level     = level + (AW+1)'(do_push) - (AW+1)'(do_pop);
        next_err_count = err_count + (AW+1)'(do_push && push_err != '0) - (AW+1)'(pop_err);
        if (!reset_n)
        begin
            next_rd_ptr    = '0;
            next_wr_ptr    = '0;
            next_level     = '0;
            next_err_count = '0;
        end
    end

    // Pointer state; reset clears pointer logic
    always_ff @(posedge sys_clk)
    begin
        rd_ptr    <= next_rd_ptr;
        wr_ptr    <= next_wr_ptr;
        level     <= next_level;
        err_count <= next_err_count;
    end

    // Storage has no reset, only pointers matter
    always_ff @(posedge sys_clk)
    begin
        if (do_push)
            err_mem[wr_ptr] <= push_err;
    end

    // Head flags read zero when empty
    always_comb
    begin
        head_err = (level == '0) ? '0 : err_mem[rd_ptr];
        any_err  = (err_count != '0);
    end
endmodule

/* design/uirc_pkg.sv */
// Package of constants for the UART interrupt, reset and sleep control block
package uirc_pkg;
    // Reset values of registers
    localparam logic [7:0] LINE_CTRL_RESET  = 8'h1d;
    localparam logic [7:0] TX_LEVEL_RESET   = 8'h40;
    localparam logic [7:0] LINE_STAT_RESET  = 8'h60;
    localparam logic [7:0] IDENT_RESET      = 8'h01;
    // Interrupt identification codes, six bits
    localparam logic [5:0] ID_NONE          = 6'h01;
    localparam logic [5:0] ID_LINE_STATUS   = 6'h06;
    localparam logic [5:0] ID_RX_TIMEOUT    = 6'h0c;
    localparam logic [5:0] ID_RX_DATA       = 6'h04;
    localparam logic [5:0] ID_TX_HOLD       = 6'h02;
    localparam logic [5:0] ID_MODEM         = 6'h00;
    localparam logic [5:0] ID_GPIO          = 6'h30;
    localparam logic [5:0] ID_FLOW_OFF      = 6'h10;
    localparam logic [5:0] ID_HANDSHAKE     = 6'h20;
    // Field positions
    localparam int IER_RX_DATA_BIT  = 0;
    localparam int IER_TX_HOLD_BIT  = 1;
    localparam int IER_LINE_BIT     = 2;
    localparam int IER_MODEM_BIT    = 3;
    localparam int IER_SLEEP_BIT    = 4;
    localparam int IER_FLOW_OFF_BIT = 5;
    localparam int IER_HSHAKE_BIT   = 7;
    localparam int EFR_ENH_BIT      = 4;
    localparam int EFR_SPECIAL_BIT  = 5;
    localparam int LCR_BREAK_BIT    = 6;
    localparam int LSR_ERR_LSB      = 2;
    localparam int LSR_FIFO_ERR_BIT = 7;
    // Time-out in character times
    localparam int RX_TIMEOUT_CHARS = 4;
    // Interrupt source index, priority order
    localparam int NUM_SRC          = 9;
    // Error flag width per entry: parity, framing, break
    localparam int ERR_W            = 3;
    // Receive FIFO depth
    localparam int FIFO_DEPTH       = 64;
    localparam int FIFO_AW          = 6;
endpackage

/* design/uirc_sync.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module uirc_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    // No reset: pins flow through it, so edge detectors start settled
    always_ff @(posedge sys_clk)
    begin
        stage1   <= async_in;
        sync_out <= stage1;
    end
endmodule

/* tb/uirc_ctrl_chk.sv */
// Assertion checker for the interrupt, reset and sleep control block
`timescale 1ns/1ps
module uirc_ctrl_chk
    import uirc_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic       soft_reset,
    input wire logic       flow_off_match,
    input wire logic       flow_on_match,
    input wire logic       rx_char_valid,
    input wire logic       rx_parity_err,
    input wire logic       tx_fifo_wr,
    input wire logic [7:0] irq_enable_reg,
    input wire logic [7:0] line_ctrl_reg,
    input wire logic [7:0] enhanced_feature_reg,
    input wire logic [7:0] irq_ident_reg,
    input wire logic [7:0] line_status_reg,
    input wire logic [7:0] tx_level_reg,
    input wire logic [6:0] rx_level,
    input wire logic       tx_serial,
    input wire logic       rts_pin,
    input wire logic       irq_n_oe,
    input wire logic       irq_n_out,
    input wire logic       uart_clk_en,
    input wire logic       asleep
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // --------------------
    // Reset and interrupt line
    // --------------------
    a_reset_values: assert property (($rose(reset_n) || $past(soft_reset)) |-> irq_ident_reg == IDENT_RESET
        && line_ctrl_reg == LINE_CTRL_RESET && irq_enable_reg == 8'h00 && tx_serial && rts_pin && !irq_n_oe)
        else $error("reset values wrong");
    a_tx_level_fixed: assert property (tx_level_reg == TX_LEVEL_RESET)
        else $error("tx level not 0x40");
    a_ident_line_tie: assert property (irq_n_oe == !irq_ident_reg[0] && irq_ident_reg[7:6] == 2'b00 && !irq_n_out)
        else $error("interrupt line disagrees with ident");
    // Match, then a quiet cycle
    sequence s_flow_off_raised;
        flow_off_match && irq_enable_reg[IER_FLOW_OFF_BIT]
        ##1 !flow_on_match && !soft_reset && irq_enable_reg[IER_FLOW_OFF_BIT];
    endsequence
    a_flow_off_irq: assert property (s_flow_off_raised |=> irq_n_oe)
        else $error("flow-off did not raise interrupt");
    a_timeout_data: assert property (irq_ident_reg[5:0] == ID_RX_TIMEOUT |-> $past(rx_level, 2) != 7'h00)
        else $error("time-out with no data");
    // --------------------
    // Receive errors, break and sleep
    // --------------------
    a_empty_no_err: assert property (rx_level == 7'h00 && $past(rx_level) == 7'h00
        |-> line_status_reg[4:2] == 3'b000 && !line_status_reg[LSR_FIFO_ERR_BIT])
        else $error("error flags with empty fifo");
    a_err_sets_flag: assert property (rx_char_valid && rx_parity_err && !soft_reset
        |-> ##[1:3] line_status_reg[LSR_FIFO_ERR_BIT])
        else $error("fifo error flag not set");
    a_break_forces: assert property (line_ctrl_reg[LCR_BREAK_BIT] && $past(line_ctrl_reg[LCR_BREAK_BIT]) |-> !tx_serial)
        else $error("break setting left tx high");
    a_sleep_allowed: assert property (asleep |-> $past(enhanced_feature_reg[EFR_ENH_BIT])
        && $past(irq_enable_reg[IER_SLEEP_BIT]) && $past(rx_level) == 7'h00 && !uart_clk_en)
        else $error("sleep without permission");
    a_wake_on_write: assert property (asleep && tx_fifo_wr |-> ##[1:3] !asleep)
        else $error("tx write did not wake");
endmodule

bind uirc_ctrl uirc_ctrl_chk u_chk (.*);

/* tb/uirc_ctrl_tb_top.sv */
// Self-checking testbench of the interrupt, reset and sleep control block
`timescale 1ns/1ps
module uirc_ctrl_tb_top;
    import uirc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset_n, soft_reset, irq_enable_wr, line_ctrl_wr, enh_feature_wr, flow_char_wr, irq_ident_rd;
    logic        rx_char_valid, rx_parity_err, rx_framing_err, rx_stop_centre, rx_fifo_rd, rx_above_trigger;
    logic        flow_on_match, flow_off_match, tx_fifo_wr, tx_hold_req, tx_empty, tx_serial_core, rts_core;
    logic        gpio_change, rx_pin, cts_pin, tx_serial, rts_pin, irq_n_out, irq_n_oe, uart_clk_en, asleep;
    logic        irq_line, poll_mode;
    logic [3:0]  modem_pins;
    logic [6:0]  rx_level;
    logic [7:0]  wdata, rx_char, irq_enable_reg, line_ctrl_reg, enhanced_feature_reg, irq_ident_reg;
    logic [7:0]  line_status_reg, modem_status_reg, tx_level_reg;
    logic [15:0] char_time;
    int          n_mismatch = 0;
    int          n_compared = 0;
    uirc_ctrl #(.CHAR_W(16)) DUT (
        .sys_clk, .reset_n, .soft_reset, .irq_enable_wr, .irq_enable_wdata(wdata), .line_ctrl_wr,
        .line_ctrl_wdata(wdata), .enh_feature_wr, .enh_feature_wdata(wdata), .flow_char_wr,
        .flow_char_wdata(wdata), .irq_ident_rd, .rx_char_valid, .rx_char, .rx_parity_err, .rx_framing_err,
        .rx_stop_centre, .rx_fifo_rd, .rx_above_trigger, .flow_on_match, .flow_off_match, .tx_fifo_wr,
        .tx_hold_req, .tx_empty, .tx_serial_core, .rts_core, .gpio_change, .char_time, .rx_pin, .modem_pins,
        .cts_pin, .irq_enable_reg, .line_ctrl_reg, .enhanced_feature_reg, .irq_ident_reg, .line_status_reg,
        .modem_status_reg, .tx_level_reg, .rx_level, .tx_serial, .rts_pin, .irq_n_out, .irq_n_oe,
        .uart_clk_en, .asleep
    );
    uirc_host_model u_host (.irq_n_out, .irq_n_oe, .irq_enable_reg, .irq_line, .poll_mode);
    always #2.5 sys_clk = ~sys_clk;
    // --------------------
    // Access tasks; inputs move 1 ns after the edge
    // --------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    // Spare cycle between calls
    task automatic wr(input int sel, input logic [7:0] d);
        wdata = d;
        {irq_enable_wr, line_ctrl_wr, enh_feature_wr, flow_char_wr} = 4'b1000 >> sel;
        tick(1);
        {irq_enable_wr, line_ctrl_wr, enh_feature_wr, flow_char_wr} = 4'h0;
        tick(1);
    endtask
    // 0 flow-off, 1 flow-on, 2 ident read, 3 fifo read, 4 tx write, 5 stop centre
    task automatic ev(input int k);
        {flow_off_match, flow_on_match, irq_ident_rd, rx_fifo_rd, tx_fifo_wr, rx_stop_centre} = 6'b100000 >> k;
        tick(1);
        {flow_off_match, flow_on_match, irq_ident_rd, rx_fifo_rd, tx_fifo_wr, rx_stop_centre} = 6'h00;
        tick(1);
    endtask
    task automatic push(input logic [7:0] d, input logic p);
        {rx_char, rx_parity_err, rx_char_valid, rx_stop_centre} = {d, p, 2'b11};
        tick(1);
        {rx_parity_err, rx_char_valid, rx_stop_centre} = 3'b000;
        tick(1);
    endtask
    // Sync plus flag and ident latency
    task automatic chk_id(input logic [5:0] code);
        tick(6);
        chk(irq_ident_reg, {2'b00, code});
        chk({7'h00, irq_line}, {7'h00, code == ID_NONE});
    endtask
    task automatic check_reset();
        chk(irq_ident_reg, IDENT_RESET);
        chk(line_ctrl_reg, LINE_CTRL_RESET);
        chk(tx_level_reg, TX_LEVEL_RESET);
        chk(line_status_reg, LINE_STAT_RESET);
        chk(modem_status_reg, {~modem_pins, 4'h0});
        chk(irq_enable_reg | enhanced_feature_reg, 8'h00);
        chk({1'b0, rx_level}, 8'h00);
        chk({5'h00, tx_serial, rts_pin, irq_line}, 8'h07);
    endtask
    task automatic test_done();
        if (n_mismatch == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // --------------------
    // Main sequence
    // --------------------
    initial
    begin
        {soft_reset, irq_enable_wr, line_ctrl_wr, enh_feature_wr, flow_char_wr, irq_ident_rd} = '0;
        {rx_char_valid, rx_parity_err, rx_framing_err, rx_stop_centre, rx_fifo_rd, rx_above_trigger} = '0;
        {flow_on_match, flow_off_match, tx_fifo_wr, gpio_change, cts_pin, modem_pins, wdata, rx_char} = '0;
        {reset_n, tx_hold_req, tx_empty, tx_serial_core, rts_core, rx_pin} = 6'b011111;
        char_time = 16'h0010;
        tick(12);
        reset_n = 1'b1;
        tick(1);
        check_reset();
        wr(0, 8'haf);
        wr(2, 8'h30);
        wr(3, 8'h5a);
        push(8'h00, 1'b1);
        chk({7'h00, line_status_reg[7]}, 8'h01);
        soft_reset = 1'b1;
        tick(1);
        soft_reset = 1'b0;
        tick(1);
        check_reset();
        tx_hold_req = 1'b0;
        wr(2, 8'h30);
        wr(0, 8'h20);
        push(8'h5a, 1'b0);
        chk_id(ID_FLOW_OFF);
        chk({1'b0, rx_level}, 8'h01);
        ev(2);
        chk_id(ID_NONE);
        ev(3);
        // Stack sources, then peel from the top
        wr(2, 8'h10);
        wr(0, 8'haf);
        cts_pin = 1'b1;
        chk_id(ID_HANDSHAKE);
        ev(0);
        chk_id(ID_FLOW_OFF);
        gpio_change = 1'b1;
        chk_id(ID_GPIO);
        modem_pins = 4'h1;
        chk_id(ID_MODEM);
        chk(modem_status_reg[7:4], 4'he);
        tx_hold_req = 1'b1;
        chk_id(ID_TX_HOLD);
        rx_above_trigger = 1'b1;
        chk_id(ID_RX_DATA);
        push(8'h00, 1'b1);
        chk_id(ID_LINE_STATUS);
        chk(line_status_reg[4:2], 3'b001);
        ev(3);
        chk_id(ID_RX_DATA);
        rx_above_trigger = 1'b0;
        chk_id(ID_TX_HOLD);
        tx_hold_req = 1'b0;
        chk_id(ID_MODEM);
        ev(2);
        chk_id(ID_GPIO);
        gpio_change = 1'b0;
        chk_id(ID_FLOW_OFF);
        ev(1);
        chk_id(ID_NONE);
        wr(0, 8'h00);
        tx_hold_req = 1'b1;
        chk_id(ID_NONE);
        chk({7'h00, poll_mode}, 8'h01);
        tx_hold_req = 1'b0;
        // Restart at 40 moves expiry past first look
        wr(0, 8'h01);
        push(8'h11, 1'b0);
        tick(40);
        ev(5);
        tick(56);
        chk(irq_ident_reg, {2'b00, ID_NONE});
        tick(16);
        chk(irq_ident_reg, {2'b00, ID_RX_TIMEOUT});
        ev(3);
        chk_id(ID_NONE);
        wr(1, 8'h40);
        tick(3);
        chk({line_ctrl_reg[7:1], tx_serial}, 8'h40);
        wr(1, 8'h00);
        tick(3);
        chk({7'h00, tx_serial}, 8'h01);
        wr(0, 8'h10);
        wr(2, 8'h00);
        tick(6);
        chk({6'h00, asleep, uart_clk_en}, 8'h01);
        wr(2, 8'h10);
        tick(6);
        chk({6'h00, asleep, uart_clk_en}, 8'h02);
        ev(4);
        tick(6);
        rx_pin = 1'b0;
        tick(5);
        chk({6'h00, asleep, uart_clk_en}, 8'h01);
        rx_pin = 1'b1;
        tick(8);
        modem_pins = 4'h3;
        tick(3);
        chk({6'h00, asleep, uart_clk_en}, 8'h01);
        test_done();
    end
    // Run needs under 1000 cycles
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        test_done();
    end
endmodule

/* tb/uirc_host_model.sv */
// Host model: pulled-up interrupt wire, poll decision
`timescale 1ns/1ps
module uirc_host_model (
    input  wire logic       irq_n_out,
    input  wire logic       irq_n_oe,
    input  wire logic [7:0] irq_enable_reg,
    output logic            irq_line,
    output logic            poll_mode
);
    // Pull-up holds the wire high when released
    assign irq_line  = irq_n_oe ? irq_n_out : 1'b1;
    // No low enable set: host polls
    assign poll_mode = (irq_enable_reg[3:0] == 4'h0);
endmodule
